// >>> design/mrb_consts.svh
`ifndef MRB_CONSTS_SVH
`define MRB_CONSTS_SVH
// mode register addresses
`define MRB_MA_CAP        6'h00
`define MRB_MA_BURST      6'h01
`define MRB_MA_LAT        6'h02
`define MRB_MA_IOINV      6'h03
`define MRB_MA_REFTH      6'h04
`define MRB_MA_MAKER      6'h05
`define MRB_MA_REV1       6'h06
`define MRB_MA_REV2       6'h07
`define MRB_MA_WDT        6'h08
`define MRB_MA_VTEST      6'h09
`define MRB_MA_ZQRST      6'h0a
`define MRB_MA_TERM       6'h0b
`define MRB_MA_CAVREF     6'h0c
`define MRB_MA_FSP        6'h0d
`define MRB_MA_DQVREF     6'h0e
`define MRB_MA_LINV       6'h0f
`define MRB_MA_PBANK      6'h10
`define MRB_MA_PSEG       6'h11
`define MRB_MA_OSCLO      6'h12
`define MRB_MA_OSCHI      6'h13
`define MRB_MA_UINV       6'h14
`define MRB_MA_RSV21      6'h15
`define MRB_MA_TERMX      6'h16
`define MRB_MA_OSCRUN     6'h17
`define MRB_MA_RHAM       6'h18
`define MRB_MA_REPAIR     6'h19
`define MRB_MA_TEST30     6'h1e
`define MRB_MA_BVREF      6'h1f
`define MRB_MA_PATA       6'h20
`define MRB_MA_TEST39     6'h27
`define MRB_MA_PATB       6'h28
// writable-bit masks, zero marks reserved_future_use bits
`define MRB_WM_FULL       8'hff
`define MRB_WM_ZQRST      8'h01
`define MRB_WM_TERM       8'h77
`define MRB_WM_DQVREF     8'h7f
`define MRB_WM_BVREF      8'hc0
`define MRB_WM_REFTH      8'hf8
// field positions
`define MRB_BST_LSB       0
`define MRB_TD_LSB        6
// reset values
`define MRB_RST_ZERO      8'h00
`define MRB_RST_PATA      8'h5a
`define MRB_RST_PATB      8'h3c
`endif

// >>> design/mrb_pkg.sv
package mrb_pkg;
  typedef enum logic [1:0] {
    MRB_BST_16, MRB_BST_32, MRB_BST_OTF, MRB_BST_RSVD
  } mrb_bst_e;
  typedef enum logic [1:0] {
    MRB_ACC_NONE, MRB_ACC_RO, MRB_ACC_WO, MRB_ACC_RW
  } mrb_acc_e;
  typedef logic [7:0] mrb_byte_t;
endpackage : mrb_pkg

// >>> design/mrb_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for pin-side levels
module mrb_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk_in,
  input  wire logic         rstn_in,
  input  wire logic         ce_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] s1_q, s1_d, s2_q, s2_d;
  // elaboration guard: a zero-width synchroniser makes no sense
  if (W < 1) begin : g_bad_width
    $error("mrb_sync width must be positive");
  end
  // stage one only feeds stage two
  always_comb begin
    s1_d = ce_in ? d_in : s1_q;
    s2_d = ce_in ? s1_q : s2_q;
  end
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end
  assign q_out = s2_q;
endmodule : mrb_sync

// >>> design/mrb_decode.sv
`timescale 1ns/1ps
`include "mrb_consts.svh"
// address classifier: access kind and writable-bit mask
module mrb_decode (
  input  wire logic [5:0]         addr_in,
  output mrb_pkg::mrb_acc_e       acc_out,
  output mrb_pkg::mrb_byte_t      wmask_out
);
  always_comb begin
    acc_out   = mrb_pkg::MRB_ACC_NONE;
    wmask_out = `MRB_WM_FULL;
    case (addr_in)
      `MRB_MA_CAP, `MRB_MA_MAKER, `MRB_MA_REV1, `MRB_MA_REV2,
      `MRB_MA_WDT, `MRB_MA_OSCLO, `MRB_MA_OSCHI,
      `MRB_MA_REPAIR:
        acc_out = mrb_pkg::MRB_ACC_RO;
      `MRB_MA_LINV, `MRB_MA_UINV, `MRB_MA_OSCRUN,
      `MRB_MA_PATA, `MRB_MA_PATB:
        acc_out = mrb_pkg::MRB_ACC_WO;
      `MRB_MA_ZQRST: begin
        acc_out   = mrb_pkg::MRB_ACC_WO;
        wmask_out = `MRB_WM_ZQRST;
      end
      `MRB_MA_BURST, `MRB_MA_LAT, `MRB_MA_IOINV, `MRB_MA_CAVREF,
      `MRB_MA_FSP, `MRB_MA_PBANK, `MRB_MA_PSEG, `MRB_MA_TERMX,
      `MRB_MA_RHAM:
        acc_out = mrb_pkg::MRB_ACC_RW;
      `MRB_MA_TERM: begin
        acc_out   = mrb_pkg::MRB_ACC_RW;
        wmask_out = `MRB_WM_TERM;
      end
      `MRB_MA_DQVREF: begin
        acc_out   = mrb_pkg::MRB_ACC_RW;
        wmask_out = `MRB_WM_DQVREF;
      end
      `MRB_MA_BVREF: begin
        acc_out   = mrb_pkg::MRB_ACC_RW;
        wmask_out = `MRB_WM_BVREF;
      end
      `MRB_MA_REFTH: begin
        acc_out   = mrb_pkg::MRB_ACC_RW;
        wmask_out = `MRB_WM_REFTH;
      end
      default: begin
        acc_out   = mrb_pkg::MRB_ACC_NONE;
        wmask_out = 8'h00;
      end
    endcase
  end
endmodule : mrb_decode

// >>> design/mrb_bank.sv
`timescale 1ns/1ps
`include "mrb_consts.svh"
////////////////////////////////////////////////////////////////////////////
module mrb_bank (
  input  wire logic                sys_clk_in,
  input  wire logic                rstn_in,
  input  wire logic                ce_in,
  input  wire logic                mrw_in,
  input  wire logic                mrr_in,
  input  wire logic [5:0]          addr_in,
  input  wire logic [7:0]          op_in,
  input  wire logic [7:0]          status_in,
  output logic      [7:0]          rdata_out,
  output logic                     rvalid_out,
  output logic      [7:0]          lower_inv_mask_out,
  output logic      [7:0]          upper_inv_mask_out,
  output logic      [1:0]          byte_mode_term_disable_out,
  output mrb_pkg::mrb_bst_e        burst_length_field_out
);
  localparam int NREG = 64;
  // maker id byte, value arbitrary and neutral
  localparam logic [7:0] MAKER_ID = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // status pins come from outside the clock domain
  logic [7:0] status_s;
  mrb_sync #(.W(8)) u_sync (
    .sys_clk_in (sys_clk_in),
    .rstn_in    (rstn_in),
    .ce_in      (ce_in),
    .d_in       (status_in),
    .q_out      (status_s)
  );

  mrb_pkg::mrb_acc_e  acc;
  mrb_pkg::mrb_byte_t wmask;
  mrb_decode u_dec (
    .addr_in   (addr_in),
    .acc_out   (acc),
    .wmask_out (wmask)
  );

  function automatic logic [7:0] rst_val(input logic [5:0] a);
    if (a == `MRB_MA_PATA)
      return `MRB_RST_PATA;
    else if (a == `MRB_MA_PATB)
      return `MRB_RST_PATB;
    else
      return `MRB_RST_ZERO;
  endfunction : rst_val

  ////////////////////////////////////////////////////////////////////////////
  // register storage, flip-flops indexed by address
  logic [7:0] mr_q [NREG];
  logic [7:0] mr_d [NREG];
  logic       wr_ok;
  // test-reserved addresses decode as none, so writes die here
  assign wr_ok = mrw_in && (acc == mrb_pkg::MRB_ACC_RW ||
                            acc == mrb_pkg::MRB_ACC_WO);

  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      mr_d[i] = mr_q[i];
    end
    // read-only slots have no write path
    if (ce_in && wr_ok)
      mr_d[addr_in] = op_in & wmask;
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < NREG; i++) begin
        mr_q[i] <= rst_val(6'(i));
      end
    end else begin
      for (int i = 0; i < NREG; i++) begin
        mr_q[i] <= mr_d[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read-only contents: status byte feeds the osc low byte only, ids arbitrary
  function automatic logic [7:0] ro_val(input logic [5:0] a,
                                        input logic [7:0] st);
    case (a)
      `MRB_MA_OSCLO: return st;
      `MRB_MA_MAKER: return MAKER_ID; // arbitrary id value
      default:       return 8'h00;
    endcase
  endfunction : ro_val

  logic [7:0] rdata_q, rdata_d;
  logic       rvalid_q, rvalid_d;
  // one-cycle read answer; write-only and unassigned give zero
  always_comb begin
    rdata_d  = rdata_q;
    rvalid_d = 1'b0;
    if (ce_in) begin
      rvalid_d = mrr_in;
      if (mrr_in) begin
        case (acc)
          mrb_pkg::MRB_ACC_RW: rdata_d = mr_q[addr_in];
          mrb_pkg::MRB_ACC_RO: rdata_d = ro_val(addr_in, status_s);
          mrb_pkg::MRB_ACC_WO: rdata_d = 8'h00;
          default:             rdata_d = 8'h00;
        endcase
      end
    end else begin
      rvalid_d = rvalid_q;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field outputs are straight flops of the bank
  assign rdata_out          = rdata_q;
  assign rvalid_out         = rvalid_q;
  assign lower_inv_mask_out = mr_q[`MRB_MA_LINV];
  assign upper_inv_mask_out = mr_q[`MRB_MA_UINV];
  assign byte_mode_term_disable_out =
    mr_q[`MRB_MA_TERMX][`MRB_TD_LSB +: 2];
  assign burst_length_field_out =
    mrb_pkg::mrb_bst_e'(mr_q[`MRB_MA_BURST][`MRB_BST_LSB +: 2]);

  ////////////////////////////////////////////////////////////////////////////
  property p_ro_keep;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && mrw_in && addr_in == `MRB_MA_CAP) |=>
      mr_q[`MRB_MA_CAP] == $past(mr_q[`MRB_MA_CAP]);
  endproperty
  a_ro_keep: assert property (p_ro_keep)
    else $error("read-only register changed");

  property p_wr_store;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && mrw_in && addr_in == `MRB_MA_PBANK) |=>
      mr_q[`MRB_MA_PBANK] == $past(op_in);
  endproperty
  a_wr_store: assert property (p_wr_store)
    else $error("write operand not stored");

  property p_rd_answer;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && mrr_in && addr_in == `MRB_MA_PSEG) |=>
      rvalid_out && rdata_out == $past(mr_q[`MRB_MA_PSEG]);
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read answer wrong");

  property p_wo_zero;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && mrr_in && addr_in == `MRB_MA_LINV) |=> rdata_out == 8'h00;
  endproperty
  a_wo_zero: assert property (p_wo_zero)
    else $error("write-only register read back");

  property p_rw_round;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && mrw_in && addr_in == `MRB_MA_PSEG) ##1
    (ce_in && mrr_in && !mrw_in && addr_in == `MRB_MA_PSEG) |=>
      rdata_out == $past(op_in, 2);
  endproperty
  a_rw_round: assert property (p_rw_round)
    else $error("read/write round trip failed");

  property p_test_ign;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && mrr_in && addr_in == `MRB_MA_TEST39) |=> rdata_out == 8'h00;
  endproperty
  a_test_ign: assert property (p_test_ign)
    else $error("test register not ignored");

  property p_linv;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && mrw_in && addr_in == `MRB_MA_LINV) |=>
      lower_inv_mask_out == $past(op_in);
  endproperty
  a_linv: assert property (p_linv)
    else $error("lower invert mask not updated");

  property p_tdis;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && mrw_in && addr_in == `MRB_MA_TERMX) |=>
      byte_mode_term_disable_out == $past(op_in[7:6]);
  endproperty
  a_tdis: assert property (p_tdis)
    else $error("termination disable field wrong");

  property p_bst_len;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && mrw_in && addr_in == `MRB_MA_BURST) |=>
      burst_length_field_out == mrb_pkg::mrb_bst_e'($past(op_in[1:0]));
  endproperty
  a_bst_len: assert property (p_bst_len)
    else $error("burst length field wrong");

  property p_rfu;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && mrw_in && addr_in == `MRB_MA_BVREF) |=>
      mr_q[`MRB_MA_BVREF][5:0] == 6'h00;
  endproperty
  a_rfu: assert property (p_rfu)
    else $error("reserved bits stored");

  // answer strobe is a single-cycle pulse
  property p_rvalid_drop;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && !mrr_in) |=> !rvalid_out;
  endproperty
  a_rvalid_drop: assert property (p_rvalid_drop)
    else $error("read valid stayed high");

  property p_rdata_hold;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && !mrr_in) |=> $stable(rdata_out);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without a read");

  // enable low must freeze read data, read valid and both invert masks
  property p_freeze;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    !ce_in |=> $stable(rdata_out) && $stable(rvalid_out) &&
      $stable(lower_inv_mask_out) && $stable(upper_inv_mask_out);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved with clock enable low");

  property p_test30_wr;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && mrw_in && addr_in == `MRB_MA_TEST30) |=>
      mr_q[`MRB_MA_TEST30] == $past(mr_q[`MRB_MA_TEST30]);
  endproperty
  a_test30_wr: assert property (p_test30_wr)
    else $error("test register took a write");

  property p_status_rd;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && mrr_in && addr_in == `MRB_MA_OSCLO) |=>
      rdata_out == $past(status_s);
  endproperty
  a_status_rd: assert property (p_status_rd)
    else $error("status byte not returned");

  property p_wo_store;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && mrw_in && addr_in == `MRB_MA_PATA) |=>
      mr_q[`MRB_MA_PATA] == $past(op_in);
  endproperty
  a_wo_store: assert property (p_wo_store)
    else $error("write-only register not stored");

  property p_term_rfu;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && mrr_in && addr_in == `MRB_MA_TERM) |=>
      (rdata_out & ~`MRB_WM_TERM) == 8'h00;
  endproperty
  a_term_rfu: assert property (p_term_rfu)
    else $error("reserved termination bits read back");

  property p_unassigned;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && mrr_in && addr_in == `MRB_MA_RSV21) |=> rdata_out == 8'h00;
  endproperty
  a_unassigned: assert property (p_unassigned)
    else $error("unassigned address read nonzero");

  property p_upper;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && mrw_in && addr_in == `MRB_MA_UINV) |=>
      upper_inv_mask_out == $past(op_in);
  endproperty
  a_upper: assert property (p_upper)
    else $error("upper invert mask not updated");

  property p_zq_mask;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && mrw_in && addr_in == `MRB_MA_ZQRST) |=>
      mr_q[`MRB_MA_ZQRST][7:1] == 7'h00;
  endproperty
  a_zq_mask: assert property (p_zq_mask)
    else $error("reserved calibration reset bits stored");
endmodule : mrb_bank

// >>> test/mrb_ctrl_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// controller model: drives mode register commands on falling edges
module mrb_ctrl_model (
  input  wire logic       sys_clk_in,
  input  wire logic       rvalid_in,
  input  wire logic [7:0] rdata_in,
  output logic            mrw_out,
  output logic            mrr_out,
  output logic [5:0]      addr_out,
  output logic [7:0]      op_out
);
  // quiet bus at time zero
  initial begin
    mrw_out = 1'b0;
    mrr_out = 1'b0;
    addr_out = 6'h2a;
    op_out = 8'h55;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one command, held across the rising edge that takes it
  task automatic issue(input logic w, input logic r, input logic [5:0] a,
                       input logic [7:0] d);
    @(negedge sys_clk_in);
    mrw_out = w;
    mrr_out = r;
    addr_out = a;
    op_out = d;
  endtask : issue
  // scramble released lines so a stale value never looks like a command
  task automatic release_bus();
    @(negedge sys_clk_in);
    mrw_out = 1'b0;
    mrr_out = 1'b0;
    addr_out = ~addr_out;
    op_out = ~op_out;
  endtask : release_bus
  // bounded wait for the read answer
  task automatic collect(output logic [7:0] d, output logic ok);
    int n;
    ok = 1'b0;
    d = 8'h00;
    for (n = 0; n < 4 && !ok; n++) begin
      if (rvalid_in === 1'b1) begin
        ok = 1'b1;
        d = rdata_in;
      end else begin
        @(negedge sys_clk_in);
      end
    end
  endtask : collect
  // plain write command
  task automatic write(input logic [5:0] a, input logic [7:0] d);
    issue(1'b1, 1'b0, a, d);
    release_bus();
  endtask : write
endmodule : mrb_ctrl_model

// >>> test/testbench.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module testbench;
  logic              sys_clk;
  logic              rstn;
  logic              ce;
  logic [7:0]        status;
  logic              mrw;
  logic              mrr;
  logic [5:0]        addr;
  logic [7:0]        op;
  logic [7:0]        rdata;
  logic              rvalid;
  logic [7:0]        lower;
  logic [7:0]        upper;
  logic [1:0]        term;
  mrb_pkg::mrb_bst_e burst;
  logic [7:0]        got;
  logic              ok;
  int                err_count;
  int                check_count;
  int                a;
  int                b;
  int                p;
  ////////////////////////////////////////////////////////////////////////////
  mrb_bank i_dut (
    .sys_clk_in(sys_clk), .rstn_in(rstn), .ce_in(ce), .mrw_in(mrw),
    .mrr_in(mrr), .addr_in(addr), .op_in(op), .status_in(status),
    .rdata_out(rdata), .rvalid_out(rvalid), .lower_inv_mask_out(lower),
    .upper_inv_mask_out(upper), .byte_mode_term_disable_out(term),
    .burst_length_field_out(burst));
  mrb_ctrl_model i_ctrl (
    .sys_clk_in(sys_clk), .rvalid_in(rvalid), .rdata_in(rdata),
    .mrw_out(mrw), .mrr_out(mrr), .addr_out(addr), .op_out(op));
  // 10 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // a missing answer ends the run rather than hanging
  task automatic rd_collect(input logic [7:0] exp);
    i_ctrl.collect(got, ok);
    if (ok !== 1'b1) begin
      check("read valid", {7'h00, ok}, 8'h01);
      give_verdict();
    end else begin
      check("read data", got, exp);
    end
  endtask : rd_collect
  task automatic rd_check(input logic [5:0] ra, input logic [7:0] exp);
    i_ctrl.issue(1'b0, 1'b1, ra, 8'h00);
    i_ctrl.release_bus();
    rd_collect(exp);
  endtask : rd_check
  // readable and writable bits per address; zero for all others
  function automatic logic [7:0] rd_mask(input logic [5:0] ma);
    case (ma)
      6'h01, 6'h02, 6'h03, 6'h0c, 6'h0d, 6'h10, 6'h11, 6'h16,
      6'h18: return 8'hff;
      6'h04: return 8'hf8;
      6'h0b: return 8'h77;
      6'h0e: return 8'h7f;
      6'h1f: return 8'hc0;
      default: return 8'h00;
    endcase
  endfunction : rd_mask
  function automatic logic [7:0] pat(input logic [5:0] ma, input int pp);
    return {ma, ma[1:0]} ^ (pp != 0 ? 8'h69 : 8'h96);
  endfunction : pat
  task automatic do_reset();
    rstn = 1'b0;
    repeat (12) @(negedge sys_clk);
    rstn = 1'b1;
  endtask : do_reset
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    status = 8'h00;
    err_count = 0;
    check_count = 0;
    do_reset();
    for (a = 0; a < 64; a++) rd_check(a[5:0], 8'h00);
    $display("test reset contents done");
    status = 8'ha5;
    // two complementary patterns catch stuck bits
    for (p = 0; p < 2; p++) begin
      for (a = 0; a < 64; a++) i_ctrl.write(a[5:0], pat(a[5:0], p));
      for (a = 0; a < 64; a++) begin
        if (a == 18) rd_check(a[5:0], 8'ha5);
        else rd_check(a[5:0], pat(a[5:0], p) & rd_mask(a[5:0]));
      end
    end
    $display("test access kinds done");
    i_ctrl.write(6'h0f, 8'h3c);
    check("lower mask", lower, 8'h3c);
    i_ctrl.write(6'h14, 8'hc3);
    check("upper mask", upper, 8'hc3);
    i_ctrl.write(6'h16, 8'h80);
    check("term disable", {6'h00, term}, 8'h02);
    rd_check(6'h16, 8'h80);
    for (b = 0; b < 4; b++) begin
      i_ctrl.write(6'h01, {6'h2b, b[1:0]});
      check("burst field", {6'h00, burst}, {6'h00, b[1:0]});
    end
    $display("test field outputs done");
    // same-cycle write and read returns the old value
    i_ctrl.issue(1'b1, 1'b1, 6'h10, 8'h22);
    i_ctrl.release_bus();
    rd_collect(pat(6'h10, 1));
    i_ctrl.issue(1'b1, 1'b0, 6'h11, 8'h33);
    i_ctrl.issue(1'b0, 1'b1, 6'h11, 8'h00);
    i_ctrl.release_bus();
    rd_collect(8'h33);
    rd_check(6'h10, 8'h22);
    // answer data stands, valid falls after one cycle
    repeat (2) @(negedge sys_clk);
    check("read data held", rdata, 8'h22);
    check("read valid drop", {7'h00, rvalid}, 8'h00);
    // clock enable low: the command is not taken
    ce = 1'b0;
    i_ctrl.write(6'h10, 8'h44);
    ce = 1'b1;
    rd_check(6'h10, 8'h22);
    $display("test ordering done");
    do_reset();
    check("lower after reset", lower, 8'h00);
    check("term after reset", {6'h00, term}, 8'h00);
    rd_check(6'h10, 8'h00);
    $display("test second reset done");
    give_verdict();
  end
endmodule : testbench
